//--- hw/pnx_pkg.sv
package pnx_pkg;

	// ---------------------------------------------------------------
	// clock and time-out figures
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TCP_ACK_TO_MS = 2500;
	localparam int unsigned TCP_ACK_TO_CYC = TCP_ACK_TO_MS * (CLK_HZ / 1000);
	// serial period: 2 * charCycles * (payload + overhead) + margin
	localparam logic [15:0] SER_OVH_CHARS = 16'h0018;
	localparam logic [31:0] SER_MARGIN_CYC = 32'h0000_0400;
	localparam logic [31:0] SER_INIT_CYC = 32'h0010_0000;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int unsigned FNUM_W = 8;
	localparam int unsigned CONN_W = 4;
	localparam logic [CONN_W-1:0] SER_CONN_ID = 4'h0;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum {
		port_initial_state,
		port_login_state,
		port_logged_in_state
	} pnx_state_type;

	typedef enum logic [2:0] {
		IU_DATA, IU_LOGIN, IU_ACK, IU_NAK, IU_DEV_RESET, IU_TIMEOUT
	} pnx_iu_type;

	typedef struct packed {
		logic valid;
		pnx_iu_type kind;
		logic login_abort_flag;
		logic [FNUM_W-1:0] frameNum;
		logic [CONN_W-1:0] connId;
		logic [31:0] period;
	} pnx_iu_info_type;

	typedef struct packed {
		logic txAbort;
		logic rxAbort;
		logic resetAck;
		logic senseLoss;
		logic resetInd;
		logic closedLogin;
	} pnx_cause_type;

endpackage : pnx_pkg

//--- hw/pnx_port_ctrl.sv
// Overview of operation
// - sending a login unit with the abort flag set raises a nexus loss.
// - receiving a login unit with the abort flag set raises a nexus loss.
// - an ACK that answers our own device reset unit raises a nexus loss.
// - the watched peer sense going from present to absent is a nexus loss.
// - each reset service indication raises a nexus loss.
// - a closed indication while in login or logged-in is a nexus loss.
// - a close event sends the port state machine straight to initial.
// - a serial port computes a new period on each parameter change.
// - frames sent after a change are timed against the new period.
// - a TCP port starts with a period of 2.5 seconds, ignoring baud rate.
// - a TCP port may load a new period from a received time-out unit.
// - a serial port carries one connection to exactly one other device.
// - TCP ports may share an interconnect, each pairing one peer only.
`timescale 1ns/1ps
module pnx_port_ctrl import pnx_pkg::*; #(
	parameter int unsigned SLOTS = 4,
	parameter logic [31:0] ACK_TCP_CYC = 32'(TCP_ACK_TO_CYC)
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// configuration levels
	input wire logic isTcp,
	input wire logic isDrivePort,
	input wire logic [CONN_W-1:0] myConn,
	// presence senses
	input wire logic autoSense,
	input wire logic driveSense,
	// service indications and events
	input wire logic resetInd,
	input wire logic closedInd,
	input wire logic closeEvt,
	input wire logic loginDone,
	// operating parameters
	input wire logic paramChange,
	input wire logic [15:0] charCycles,
	input wire logic [15:0] maxPayload,
	// transmitted and received units
	input wire pnx_iu_info_type txIu,
	output logic txReady,
	input wire pnx_iu_info_type rxIu,
	// status
	output pnx_state_type portState,
	output logic nexusLoss,
	output pnx_cause_type lossCause,
	output logic ackTimeout,
	output logic [FNUM_W-1:0] timeoutFrame,
	output logic [31:0] ackPeriod
);

	// ---------------------------------------------------------------
	// accepted units
	// ---------------------------------------------------------------
	// a serial link only answers on its single connection
	// a shared TCP link filters on this port's own peer
	wire logic [CONN_W-1:0] wantConn = isTcp ? myConn : SER_CONN_ID;
	wire logic txFire = txIu.valid && txReady;
	wire logic rxOk = rxIu.valid && (rxIu.connId == wantConn);
	wire logic txTimed = txFire && (txIu.kind != IU_ACK) &&
		(txIu.kind != IU_NAK);
	wire logic rxAnswer = rxOk && ((rxIu.kind == IU_ACK) ||
		(rxIu.kind == IU_NAK));

	// ---------------------------------------------------------------
	// nexus loss causes
	// ---------------------------------------------------------------
	logic senseSeen_r;
	logic rstPend_r;
	logic [FNUM_W-1:0] rstFrame_r;
	pnx_state_type state_r, state_nxt;
	pnx_cause_type cause_nxt;

	wire logic peerSense = isDrivePort ? autoSense : driveSense;
	wire logic inLogin = (state_r == port_login_state) ||
		(state_r == port_logged_in_state);
	wire logic closing = closeEvt || closedInd;

	always_comb begin
		cause_nxt.txAbort = txFire && (txIu.kind == IU_LOGIN) &&
			txIu.login_abort_flag;
		cause_nxt.rxAbort = rxOk && (rxIu.kind == IU_LOGIN) &&
			rxIu.login_abort_flag;
		cause_nxt.resetAck = rxOk && (rxIu.kind == IU_ACK) && rstPend_r &&
			(rxIu.frameNum == rstFrame_r);
		cause_nxt.senseLoss = senseSeen_r && !peerSense;
		cause_nxt.resetInd = resetInd;
		// closed while logging in or logged in
		cause_nxt.closedLogin = closedInd && inLogin;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			lossCause <= '0;
			nexusLoss <= 1'b0;
			senseSeen_r <= 1'b0;
		end else begin
			lossCause <= cause_nxt;
			nexusLoss <= |cause_nxt;
			senseSeen_r <= peerSense;
		end
	end

	// device reset unit outstanding; a new one wins over the answer
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rstPend_r <= 1'b0;
			rstFrame_r <= '0;
		end else if (txFire && txIu.kind == IU_DEV_RESET) begin
			rstPend_r <= 1'b1;
			rstFrame_r <= txIu.frameNum;
		end else if (cause_nxt.resetAck) begin
			rstPend_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// port state machine
	// ---------------------------------------------------------------
	wire logic loginSeen = (txFire && txIu.kind == IU_LOGIN) ||
		(rxOk && rxIu.kind == IU_LOGIN);
	wire logic abortSeen = cause_nxt.txAbort || cause_nxt.rxAbort;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			port_initial_state: begin
				if (loginSeen && !abortSeen)
					state_nxt = port_login_state;
			end
			port_login_state: begin
				if (abortSeen)
					state_nxt = port_initial_state;
				else if (loginDone)
					state_nxt = port_logged_in_state;
			end
			port_logged_in_state: begin
				if (abortSeen)
					state_nxt = port_initial_state;
			end
			default: state_nxt = port_initial_state;
		endcase
		if (closing)
			state_nxt = port_initial_state;
	end

	always_ff @(posedge clk) begin
		if (!nrst)
			state_r <= port_initial_state;
		else
			state_r <= state_nxt;
	end
	assign portState = state_r;

	// ---------------------------------------------------------------
	// acknowledgement period
	// ---------------------------------------------------------------
	wire logic [31:0] serProd = 32'(charCycles) *
		32'(maxPayload + SER_OVH_CHARS);
	wire logic [31:0] serPeriod = 32'(serProd << 1) + SER_MARGIN_CYC;
	wire logic loadTo = isTcp && rxOk && (rxIu.kind == IU_TIMEOUT) &&
		(rxIu.period != '0);

	always_ff @(posedge clk) begin
		if (!nrst)
			ackPeriod <= isTcp ? ACK_TCP_CYC : SER_INIT_CYC;
		else if (!isTcp && paramChange)
			ackPeriod <= serPeriod;
		else if (loadTo)
			ackPeriod <= rxIu.period;
	end

	// ---------------------------------------------------------------
	// per-frame timers
	// ---------------------------------------------------------------
	logic [SLOTS-1:0] slotBusy;
	logic [SLOTS-1:0] slotDone;
	logic [SLOTS-1:0] slotFree;
	logic [SLOTS-1:0] slotTake;
	logic [SLOTS-1:0] slotRep;
	logic [FNUM_W-1:0] slotNum [SLOTS];

	// lowest free slot takes the frame, lowest expired one reports
	always_comb begin
		slotTake = '0;
		slotRep = '0;
		for (int i = 0; i < SLOTS; i++) begin
			if (!slotBusy[i] && slotTake == '0)
				slotTake[i] = txTimed;
			if (slotDone[i] && slotRep == '0)
				slotRep[i] = 1'b1;
		end
	end
	assign txReady = (txIu.kind == IU_ACK) || (txIu.kind == IU_NAK) ||
		(slotFree != '0);

	for (genvar g = 0; g < SLOTS; g++) begin : g_slot
		logic busy_r;
		logic [31:0] cnt_r;
		logic [FNUM_W-1:0] num_r;
		wire logic hit = rxAnswer && busy_r && (rxIu.frameNum == num_r);
		assign slotBusy[g] = busy_r;
		assign slotFree[g] = !busy_r;
		assign slotDone[g] = busy_r && (cnt_r == '0);
		assign slotNum[g] = num_r;
		always_ff @(posedge clk) begin
			if (!nrst) begin
				busy_r <= 1'b0;
				cnt_r <= '0;
				num_r <= '0;
			end else if (closing) begin
				// close drops every timer, one starting now too
				busy_r <= 1'b0;
			end else if (slotTake[g]) begin
				// each frame keeps the period current at its send
				busy_r <= 1'b1;
				cnt_r <= ackPeriod - 32'h1;
				num_r <= txIu.frameNum;
			end else if (hit || slotRep[g]) begin
				busy_r <= 1'b0;
			end else if (busy_r && cnt_r != '0) begin
				cnt_r <= cnt_r - 32'h1;
			end
		end
	end

	logic [FNUM_W-1:0] repNum;
	always_comb begin
		repNum = '0;
		for (int i = 0; i < SLOTS; i++)
			if (slotRep[i])
				repNum = slotNum[i];
	end

	// flag the lowest-numbered expired slot, one per cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ackTimeout <= 1'b0;
			timeoutFrame <= '0;
		end else begin
			ackTimeout <= (slotRep != '0) && !closing;
			timeoutFrame <= repNum;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_tx_abort;
		@(posedge clk) disable iff (!nrst)
		txFire && txIu.kind == IU_LOGIN && txIu.login_abort_flag
			|=> nexusLoss && lossCause.txAbort;
	endproperty
	a_tx_abort: assert property (p_tx_abort)
		else $error("sent abort without nexus loss");

	property p_rx_abort;
		@(posedge clk) disable iff (!nrst)
		rxOk && rxIu.kind == IU_LOGIN && rxIu.login_abort_flag
			|=> lossCause.rxAbort ##0 nexusLoss;
	endproperty
	a_rx_abort: assert property (p_rx_abort)
		else $error("received abort without nexus loss");

	property p_reset_ack;
		@(posedge clk) disable iff (!nrst)
		lossCause.resetAck |-> $past(rstPend_r) && nexusLoss;
	endproperty
	a_reset_ack: assert property (p_reset_ack)
		else $error("reset ack loss without pending reset");

	property p_sense;
		@(posedge clk) disable iff (!nrst)
		$past(nrst) && $fell(peerSense) && !$rose(isDrivePort) &&
			!$fell(isDrivePort) |=> nexusLoss;
	endproperty
	a_sense: assert property (p_sense)
		else $error("sense loss missed");

	property p_reset_ind;
		@(posedge clk) disable iff (!nrst)
		resetInd |=> lossCause.resetInd && nexusLoss;
	endproperty
	a_reset_ind: assert property (p_reset_ind)
		else $error("reset indication missed");

	property p_closed;
		@(posedge clk) disable iff (!nrst)
		closedInd && portState != port_initial_state
			|=> nexusLoss ##0 portState == port_initial_state;
	endproperty
	a_closed: assert property (p_closed)
		else $error("closed in login not a nexus loss");

	property p_close;
		@(posedge clk) disable iff (!nrst)
		closeEvt |=> portState == port_initial_state && slotBusy == '0;
	endproperty
	a_close: assert property (p_close)
		else $error("close did not reach initial");

	property p_param;
		@(posedge clk) disable iff (!nrst)
		!isTcp && paramChange ##1 !isTcp |-> ackPeriod == $past(serPeriod);
	endproperty
	a_param: assert property (p_param)
		else $error("serial period not recomputed");

	property p_tcp_start;
		@(posedge clk)
		!nrst && isTcp ##1 !nrst |-> ackPeriod == ACK_TCP_CYC;
	endproperty
	a_tcp_start: assert property (p_tcp_start)
		else $error("tcp start period wrong");

	property p_no_timeout_idle;
		@(posedge clk) disable iff (!nrst)
		slotBusy == '0 && !txTimed |=> !ackTimeout;
	endproperty
	a_no_timeout_idle: assert property (p_no_timeout_idle)
		else $error("time-out with no frame outstanding");

endmodule : pnx_port_ctrl

//--- verif/pnx_peer_model.sv
`timescale 1ns/1ps
module pnx_peer_model import pnx_pkg::*; (
	// port side
	input wire logic clk,
	input wire pnx_iu_info_type txIu,
	input wire logic txReady,
	output pnx_iu_info_type rxIu
);
	// ackDelay below zero leaves frames unanswered
	int ackDelay = 3;
	logic [CONN_W-1:0] ackConn = 4'h0;
	// answer with NAK instead of ACK
	logic useNak = 0;
	int cyc = 0;
	int due[$];
	logic [FNUM_W-1:0] fq[$];
	pnx_iu_info_type outq[$];
	pnx_iu_info_type iu;
	initial rxIu = '0;
	// note each timed frame taken at the coming edge
	always @(negedge clk) begin
		if (txIu.valid && txReady && ackDelay >= 0 && txIu.kind != IU_ACK &&
			txIu.kind != IU_NAK) begin
			due.push_back(cyc + 1 + ackDelay);
			fq.push_back(txIu.frameNum);
		end
	end
	// idle cycles carry a changing pattern, not the last unit
	always @(posedge clk) begin
		cyc++;
		#1;
		iu = pnx_iu_info_type'({1'b0, 48'({$urandom, $urandom})});
		if (due.size() > 0 && due[0] <= cyc) begin
			iu = '0;
			iu.valid = 1;
			iu.kind = useNak ? IU_NAK : IU_ACK;
			iu.frameNum = fq.pop_front();
			iu.connId = ackConn;
			void'(due.pop_front());
		end else if (outq.size() > 0) begin
			iu = outq.pop_front();
		end
		rxIu = iu;
	end
endmodule : pnx_peer_model

//--- verif/test_port_nexus_loss_ack_timeout.sv
`timescale 1ns/1ps
module test_port_nexus_loss_ack_timeout import pnx_pkg::*;;
	localparam int P_TCP = 200;
	logic clk = 0, nrst = 0, isTcp = 1, isDrivePort = 1;
	logic autoSense = 1, driveSense = 1, resetInd = 0, closedInd = 0;
	logic closeEvt = 0, loginDone = 0, paramChange = 0;
	logic [CONN_W-1:0] myConn = 4'h3;
	logic [15:0] charCycles = 16'h0001, maxPayload = 16'h0000;
	pnx_iu_info_type txIu = '0, rxIu, iu;
	logic txReady, nexusLoss, ackTimeout;
	pnx_state_type portState;
	pnx_cause_type lossCause;
	logic [FNUM_W-1:0] timeoutFrame;
	logic [31:0] ackPeriod;
	int failures = 0, checksDone = 0, cyc = 0, expPer, seed;
	pnx_cause_type lossQ[$];
	int toAt[$];
	logic [FNUM_W-1:0] toFr[$];

	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	pnx_port_ctrl #(.ACK_TCP_CYC(32'(P_TCP))) uut (.clk(clk), .nrst(nrst),
		.isTcp(isTcp), .isDrivePort(isDrivePort), .myConn(myConn),
		.autoSense(autoSense), .driveSense(driveSense), .resetInd(resetInd),
		.closedInd(closedInd), .closeEvt(closeEvt), .loginDone(loginDone),
		.paramChange(paramChange), .charCycles(charCycles),
		.maxPayload(maxPayload), .txIu(txIu), .txReady(txReady), .rxIu(rxIu),
		.portState(portState), .nexusLoss(nexusLoss), .lossCause(lossCause),
		.ackTimeout(ackTimeout), .timeoutFrame(timeoutFrame),
		.ackPeriod(ackPeriod));
	pnx_peer_model peer (.clk(clk), .txIu(txIu), .txReady(txReady),
		.rxIu(rxIu));

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1;
		tick(1);
		s = 0;
	endtask : pulse
	function automatic pnx_cause_type cz(int b);
		return pnx_cause_type'(6'(1 << b));
	endfunction : cz
	// silent marks a frame that must time out; more keeps valid up
	task send(pnx_iu_type k, logic ab, logic [7:0] f, logic silent, more);
		int w;
		pnx_iu_info_type t;
		t = '0;
		t.valid = 1;
		t.kind = k;
		t.login_abort_flag = ab;
		t.frameNum = f;
		t.connId = myConn;
		txIu = t;
		w = 0;
		// ready is judged settled mid-cycle, taken at the next edge
		@(negedge clk);
		while (txReady !== 1'b1 && w < 50) begin
			@(negedge clk);
			w++;
		end
		check(txReady, 1);
		tick(1);
		if (!more) txIu.valid = 0;
		if (silent) begin
			toAt.push_back(cyc + expPer + 1);
			toFr.push_back(f);
		end
	endtask : send
	task endOfTest;
		check(lossQ.size(), 0);
		check(toAt.size(), 0);
		$display("checks %0d, failures %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : endOfTest

	// ----------------------------------------------------------
	// result monitor against the expectation queues
	// ----------------------------------------------------------
	always @(negedge clk) if (nrst) begin
		if (nexusLoss === 1'b1) begin
			check(lossQ.size() > 0, 1);
			if (lossQ.size() > 0) check(lossCause, lossQ.pop_front());
		end
		if (ackTimeout === 1'b1) begin
			check(toAt.size() > 0, 1);
			if (toAt.size() > 0) begin
				check(timeoutFrame, toFr.pop_front());
				check((toAt.pop_front() - cyc) inside {0, 1}, 1);
			end
		end
	end

	initial begin
		tick(20000);
		failures++;
		endOfTest;
	end

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	initial begin
		seed = $urandom(32'h878c0422);
		peer.ackConn = myConn;
		expPer = P_TCP;
		tick(4);
		nrst = 1;
		check(ackPeriod, P_TCP);
		check(portState, port_initial_state);
		lossQ.push_back(cz(5));
		send(IU_LOGIN, 1, 8'h01, 0, 0);
		iu = '0;
		iu.valid = 1;
		iu.kind = IU_LOGIN;
		iu.login_abort_flag = 1;
		iu.connId = 4'h5;
		peer.outq.push_back(iu);
		iu.connId = myConn;
		lossQ.push_back(cz(4));
		peer.outq.push_back(iu);
		tick(4);
		send(IU_LOGIN, 0, 8'h02, 0, 0);
		check(portState, port_login_state);
		pulse(loginDone);
		check(portState, port_logged_in_state);
		lossQ.push_back(cz(0));
		pulse(closedInd);
		check(portState, port_initial_state);
		send(IU_LOGIN, 0, 8'h03, 0, 0);
		pulse(closeEvt);
		check(portState, port_initial_state);
		lossQ.push_back(cz(3));
		send(IU_DEV_RESET, 0, 8'h04, 0, 0);
		tick(6);
		lossQ.push_back(cz(2));
		driveSense = 0;
		autoSense = 0;
		tick(2);
		lossQ.push_back(cz(1));
		pulse(resetInd);
		tick(2);
		// unanswered frames fill every slot, then time out
		peer.ackDelay = -1;
		for (int i = 0; i < 4; i++) send(IU_DATA, 0, 8'($urandom), 1, i < 3);
		check(txReady, 0);
		tick(expPer + 6);
		peer.ackDelay = 5;
		peer.useNak = 1;
		send(IU_DATA, 0, 8'h20, 0, 0);
		tick(expPer + 6);
		// time-out unit loads a period, zero is ignored
		iu = '0;
		iu.valid = 1;
		iu.kind = IU_TIMEOUT;
		iu.connId = myConn;
		iu.period = 32'h0000_012c;
		peer.outq.push_back(iu);
		iu.period = '0;
		peer.outq.push_back(iu);
		tick(3);
		check(ackPeriod, 32'h0000_012c);
		expPer = 300;
		peer.ackDelay = -1;
		send(IU_DATA, 0, 8'h21, 1, 0);
		tick(expPer + 6);
		// serial link: period follows the operating parameters
		nrst = 0;
		isTcp = 0;
		tick(4);
		nrst = 1;
		check(ackPeriod, SER_INIT_CYC);
		// automation-side port watches the drive sense
		isDrivePort = 0;
		driveSense = 1;
		tick(2);
		lossQ.push_back(cz(2));
		driveSense = 0;
		tick(2);
		charCycles = 16'($urandom_range(1, 3));
		maxPayload = 16'($urandom_range(0, 40));
		pulse(paramChange);
		expPer = 2 * charCycles * (maxPayload + SER_OVH_CHARS) +
			SER_MARGIN_CYC;
		check(ackPeriod, expPer);
		// an ACK on a foreign connection id is not ours
		peer.ackDelay = 2;
		peer.ackConn = myConn;
		send(IU_DATA, 0, 8'h30, 1, 0);
		tick(expPer + 6);
		endOfTest;
	end
endmodule : test_port_nexus_loss_ack_timeout
